/* shared/fpep_pkg.sv */
// Package for the flash program/erase protection block.
// Assumes one 20 MHz system clock and an 8-bit register port.
package fpep_pkg;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [1:0] OFF_CTRL_ONE = 2'h0;
    localparam logic [1:0] OFF_CTRL_TWO = 2'h1;
    localparam logic [1:0] OFF_SEL_ONE  = 2'h2;
    localparam logic [1:0] OFF_SEL_TWO  = 2'h3;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int BIT_PROG_REQ  = 0;
    localparam int BIT_ERASE_REQ = 1;
    localparam int BIT_PROG_VER  = 2;
    localparam int BIT_ERASE_VER = 3;
    localparam int BIT_SW_WE     = 6;
    localparam int BIT_ERR_FLAG  = 7;

    // ----------------------------------------
    // Reset values and masks
    // ----------------------------------------
    localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
    localparam logic [7:0] CTRL_ONE_MASK  = 8'h4F;
    localparam logic [7:0] SEL_RESET      = 8'h00;
    localparam logic [7:0] RDATA_IDLE     = 8'h00;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {
        OP_IDLE,
        OP_PROGRAM,
        OP_ERASE
    } fpep_op_t;

    typedef struct packed {
        logic flash_read;
        logic exception_start;
        logic sleep_exec;
    } fpep_cpu_event_t;

    typedef struct packed {
        logic watchdog_reset;
        logic hw_standby;
        logic sw_standby;
        logic sub_active;
        logic sub_sleep;
        logic watch_mode;
    } fpep_power_t;

endpackage : fpep_pkg

/* logic/fpep_error_guard.sv */
// Error protection latch for the flash program/erase protection block.
// Assumes events are synchronous to sys_clk and one cycle or longer.
`timescale 1ns/10ps

module fpep_error_guard (
    // Clock and reset
    input  wire logic                      sys_clk,
    input  wire logic                      reset,
    // Conditions
    input  wire logic                      hw_standby,
    input  wire logic                      op_active,
    input  wire fpep_pkg::fpep_cpu_event_t cpu_event,
    // Result
    output logic                           error_hit,
    output logic                           error_flag
);

    // ----------------------------------------
    // Error detection
    // ----------------------------------------
    logic next_error_flag;

    always_comb begin
        error_hit = op_active & (cpu_event.flash_read
                               | cpu_event.exception_start
                               | cpu_event.sleep_exec);
        // Set wins over the standby release
        next_error_flag = error_hit | (error_flag & ~hw_standby);
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            error_flag <= 1'b0;
        end else begin
            error_flag <= next_error_flag;
        end
    end

endmodule : fpep_error_guard

/* logic/fpep_protect.sv */
// Flash program/erase protection: control registers, mode gating,
// hardware, software and error protection.
// Assumes a CPU register port with read data one cycle after the strobe,
// and CPU and power-mode events synchronous to sys_clk.
//
// How it works
// - Reset or any low-power mode entry aborts and forbids program and erase.
// - Hardware protection returns the first control and both block registers to reset.
// - With write enable clear, program or erase request enters no mode.
// - Only selected blocks are erased; all-zero selection protects every block.
// - Flash read during program or erase sets the error flag.
// - Non-reset exception start during program or erase sets the error flag.
// - Low-power instruction during program or erase sets the error flag.
// - Error keeps register contents and stops program or erase at once.
// - Under error, program and erase requests start nothing.
// - Under error, verify bits still enter verify modes.
// - Only reset or hardware standby clears the error state.
// - Flash reads while a request bit is set return undefined data.
// - With write enable set, flash reads allowed only in verify modes.
// - Erase lasts exactly as long as the erase request stays set.
//
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/10ps

module fpep_protect #(
    parameter int BLOCK_BITS = 8
) (
    // Clock and reset
    input  wire logic                      sys_clk,
    input  wire logic                      reset,
    // Register port
    input  wire logic [1:0]                reg_addr,
    input  wire logic [7:0]                reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output logic [7:0]                     reg_rdata,
    // CPU and power-mode events
    input  wire fpep_pkg::fpep_cpu_event_t cpu_event,
    input  wire fpep_pkg::fpep_power_t     power,
    // Flash array control
    output logic                           program_mode,
    output logic                           erase_mode,
    output logic                           program_verify_mode,
    output logic                           erase_verify_mode,
    output logic [2*BLOCK_BITS-1:0]        erase_block_enable,
    output logic                           read_permit,
    output logic                           read_undefined,
    output logic                           error_protect
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic wr_hit(input logic       wr,
                                    input logic [1:0] addr,
                                    input logic [1:0] off);
        wr_hit = wr & (addr == off);
    endfunction : wr_hit

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [7:0]              flash_ctrl_reg_one;
    logic [BLOCK_BITS-1:0]   erase_block_sel_one;
    logic [BLOCK_BITS-1:0]   erase_block_sel_two;
    fpep_pkg::fpep_op_t      op;
    fpep_pkg::fpep_op_t      next_op;
    logic                    hw_protect;
    logic                    software_write_enable;
    logic                    prog_req;
    logic                    erase_req;
    logic                    program_verify_bit;
    logic                    erase_verify_bit;
    logic                    flash_error_flag;
    logic                    error_hit;
    logic                    op_allow;
    logic                    next_pv_mode;
    logic                    next_ev_mode;
    logic [2*BLOCK_BITS-1:0] sel_all;
    logic [7:0]              next_rdata;

    assign software_write_enable = flash_ctrl_reg_one[fpep_pkg::BIT_SW_WE];
    assign prog_req              = flash_ctrl_reg_one[fpep_pkg::BIT_PROG_REQ];
    assign erase_req             = flash_ctrl_reg_one[fpep_pkg::BIT_ERASE_REQ];
    assign program_verify_bit    = flash_ctrl_reg_one[fpep_pkg::BIT_PROG_VER];
    assign erase_verify_bit      = flash_ctrl_reg_one[fpep_pkg::BIT_ERASE_VER];
    assign sel_all               = {erase_block_sel_two, erase_block_sel_one};
    assign error_protect         = flash_error_flag;

    // ----------------------------------------
    // Hardware protection
    // ----------------------------------------
    assign hw_protect = power.watchdog_reset
                      | power.hw_standby
                      | power.sw_standby
                      | power.sub_active
                      | power.sub_sleep
                      | power.watch_mode;

    // ----------------------------------------
    // Error protection latch
    // ----------------------------------------
    fpep_error_guard u_guard (
        .sys_clk    (sys_clk),
        .reset      (reset),
        .hw_standby (power.hw_standby),
        .op_active  (program_mode | erase_mode),
        .cpu_event  (cpu_event),
        .error_hit  (error_hit),
        .error_flag (flash_error_flag)
    );

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    // Error protection leaves these alone; only reset or hardware protection clears
    always_ff @(posedge sys_clk) begin
        if (reset || hw_protect) begin
            flash_ctrl_reg_one <= fpep_pkg::CTRL_ONE_RESET;
        end else if (wr_hit(reg_wr, reg_addr, fpep_pkg::OFF_CTRL_ONE)) begin
            flash_ctrl_reg_one <= reg_wdata & fpep_pkg::CTRL_ONE_MASK;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset || hw_protect) begin
            erase_block_sel_one <= BLOCK_BITS'(fpep_pkg::SEL_RESET);
        end else if (wr_hit(reg_wr, reg_addr, fpep_pkg::OFF_SEL_ONE)) begin
            erase_block_sel_one <= reg_wdata[BLOCK_BITS-1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset || hw_protect) begin
            erase_block_sel_two <= BLOCK_BITS'(fpep_pkg::SEL_RESET);
        end else if (wr_hit(reg_wr, reg_addr, fpep_pkg::OFF_SEL_TWO)) begin
            erase_block_sel_two <= reg_wdata[BLOCK_BITS-1:0];
        end
    end

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    // Writes to the second control register are dropped
    always_comb begin
        next_rdata = fpep_pkg::RDATA_IDLE;
        if (reg_rd) begin
            unique case (reg_addr)
                fpep_pkg::OFF_CTRL_ONE: next_rdata = flash_ctrl_reg_one;
                fpep_pkg::OFF_CTRL_TWO: begin
                    next_rdata[fpep_pkg::BIT_ERR_FLAG] = flash_error_flag;
                end
                fpep_pkg::OFF_SEL_ONE:  next_rdata[BLOCK_BITS-1:0] = erase_block_sel_one;
                fpep_pkg::OFF_SEL_TWO:  next_rdata[BLOCK_BITS-1:0] = erase_block_sel_two;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            reg_rdata <= fpep_pkg::RDATA_IDLE;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // ----------------------------------------
    // Operation sequencing
    // ----------------------------------------
    // A detected error halts the mode on the very next edge
    assign op_allow = software_write_enable
                    & ~flash_error_flag
                    & ~error_hit
                    & ~hw_protect;

    always_comb begin
        next_op = fpep_pkg::OP_IDLE;
        unique case (op)
            fpep_pkg::OP_IDLE: begin
                if (op_allow && prog_req) begin
                    next_op = fpep_pkg::OP_PROGRAM;
                end else if (op_allow && erase_req) begin
                    next_op = fpep_pkg::OP_ERASE;
                end
            end
            fpep_pkg::OP_PROGRAM: begin
                if (op_allow && prog_req) begin
                    next_op = fpep_pkg::OP_PROGRAM;
                end
            end
            fpep_pkg::OP_ERASE: begin
                // Erase time is exactly the request's high time
                if (op_allow && erase_req) begin
                    next_op = fpep_pkg::OP_ERASE;
                end
            end
            default: next_op = fpep_pkg::OP_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            op <= fpep_pkg::OP_IDLE;
        end else begin
            op <= next_op;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            program_mode <= 1'b0;
            erase_mode   <= 1'b0;
        end else begin
            program_mode <= (next_op == fpep_pkg::OP_PROGRAM);
            erase_mode   <= (next_op == fpep_pkg::OP_ERASE);
        end
    end

    // ----------------------------------------
    // Block selection
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            erase_block_enable <= '0;
        end else if (next_op == fpep_pkg::OP_ERASE) begin
            erase_block_enable <= sel_all;
        end else begin
            erase_block_enable <= '0;
        end
    end

    // ----------------------------------------
    // Verify modes and read gating
    // ----------------------------------------
    // Verify ignores the error state on purpose
    assign next_pv_mode = software_write_enable & program_verify_bit & ~hw_protect;
    assign next_ev_mode = software_write_enable & erase_verify_bit & ~hw_protect;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            program_verify_mode <= 1'b0;
            erase_verify_mode   <= 1'b0;
        end else begin
            program_verify_mode <= next_pv_mode;
            erase_verify_mode   <= next_ev_mode;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            read_permit    <= 1'b1;
            read_undefined <= 1'b0;
        end else begin
            read_permit    <= (~software_write_enable | next_pv_mode | next_ev_mode)
                            & (next_op == fpep_pkg::OP_IDLE);
            read_undefined <= prog_req | erase_req;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    // Erase started from idle or already running, request kept for a second cycle
    sequence erase_held_s;
        op != fpep_pkg::OP_PROGRAM && op_allow && erase_req && !prog_req
            ##1 op_allow && erase_req;
    endsequence

    sequence error_cause_s;
        (program_mode || erase_mode)
            && (cpu_event.flash_read || cpu_event.exception_start
                || cpu_event.sleep_exec);
    endsequence

    hw_abort_a: assert property (hw_protect |=> !program_mode && !erase_mode)
        else $error("mode active after hardware protection");

    hw_init_a: assert property (hw_protect |=> flash_ctrl_reg_one == 8'h00
                                && sel_all == '0)
        else $error("registers not cleared by hardware protection");

    swe_gate_a: assert property (!software_write_enable
                                 |=> !program_mode && !erase_mode)
        else $error("mode entered with write enable clear");

    erase_sel_a: assert property (sel_all == '0 |=> erase_block_enable == '0)
        else $error("block enabled with empty selection");

    err_set_a: assert property (error_cause_s |=> flash_error_flag)
        else $error("error flag not set by fault in operation");

    err_hold_a: assert property (flash_error_flag && !hw_protect && !reg_wr
                                 |=> $stable(flash_ctrl_reg_one)
                                     && $stable(sel_all))
        else $error("registers changed under error protection");

    err_block_a: assert property (error_cause_s
                                  |=> !program_mode && !erase_mode
                                  ##1 !program_mode && !erase_mode)
        else $error("mode continued after error");

    verify_ok_a: assert property (flash_error_flag && software_write_enable
                                  && program_verify_bit && !hw_protect
                                  |=> program_verify_mode)
        else $error("verify refused under error protection");

    err_sticky_a: assert property (flash_error_flag && !power.hw_standby
                                   |=> flash_error_flag)
        else $error("error flag released without reset or standby");

    erase_len_a: assert property (erase_held_s |-> erase_mode ##1 erase_mode)
        else $error("erase mode does not follow the request");

    erase_stop_a: assert property (erase_mode && !erase_req |=> !erase_mode)
        else $error("erase mode outlived the erase request");

    erase_map_a: assert property (erase_mode |-> erase_block_enable == $past(sel_all))
        else $error("erased blocks differ from the selection");

    read_gate_a: assert property (software_write_enable && !next_pv_mode
                                  && !next_ev_mode |=> !read_permit)
        else $error("read permitted outside verify with write enable set");

    undef_flag_a: assert property (prog_req || erase_req |=> read_undefined)
        else $error("undefined-read indication missing with a request set");

    err_release_a: assert property (power.hw_standby && !error_hit
                                    |=> !flash_error_flag)
        else $error("error flag kept through hardware standby");

    err_flag_ro_a: assert property (reg_wr && reg_addr == fpep_pkg::OFF_CTRL_TWO
                                    && !error_hit && !power.hw_standby
                                    |=> flash_error_flag == $past(flash_error_flag))
        else $error("error flag changed by a register write");

    verify_ev_a: assert property (flash_error_flag && software_write_enable
                                  && erase_verify_bit && !hw_protect
                                  |=> erase_verify_mode)
        else $error("erase verify refused under error protection");

endmodule : fpep_protect

/* bench/fpep_cpu_model.sv */
// CPU-side model: register port master, CPU event and power-mode sources.
// Assumes the block samples all of these on the rising edge of sys_clk.
`timescale 1ns/10ps

module fpep_cpu_model (
    // Clock
    input  wire logic                 sys_clk,
    // Register port
    output logic [1:0]                reg_addr,
    output logic [7:0]                reg_wdata,
    output logic                      reg_wr,
    output logic                      reg_rd,
    input  wire logic [7:0]           reg_rdata,
    // Events
    output fpep_pkg::fpep_cpu_event_t cpu_event,
    output fpep_pkg::fpep_power_t     power
);
    initial begin
        reg_addr = 2'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        cpu_event = '0;
        power = '0;
    end

    // ----------------------------------------
    // Register access
    // ----------------------------------------
    // Write data is inverted after release so a stale value never looks valid
    // Software never clears write enable by a write and programs no unit twice;
    // the watchdog is taken as armed before any request
    task automatic write_reg(input logic [1:0] addr, input logic [7:0] data);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= addr;
        reg_wdata <= data;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~data;
    endtask : write_reg

    task automatic read_reg(input logic [1:0] addr, output logic [7:0] data);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= addr;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        data = reg_rdata;
    endtask : read_reg

    // ----------------------------------------
    // Events
    // ----------------------------------------
    // Interrupts stay masked; events appear only when a test injects a fault
    task automatic pulse_event(input fpep_pkg::fpep_cpu_event_t ev);
        @(posedge sys_clk);
        cpu_event <= ev;
        @(posedge sys_clk);
        cpu_event <= '0;
    endtask : pulse_event

    task automatic pulse_power(input fpep_pkg::fpep_power_t pw);
        @(posedge sys_clk);
        power <= pw;
        @(posedge sys_clk);
        power <= '0;
    endtask : pulse_power
endmodule : fpep_cpu_model

/* bench/test_flash_program_erase_protection.sv */
// Testbench for the flash program/erase protection block.
// Assumes the CPU model drives the register port and all event inputs.
`timescale 1ns/10ps

module test_flash_program_erase_protection;
    logic                      sys_clk;
    logic                      reset;
    logic [1:0]                reg_addr;
    logic [7:0]                reg_wdata;
    logic                      reg_wr;
    logic                      reg_rd;
    logic [7:0]                reg_rdata;
    fpep_pkg::fpep_cpu_event_t cpu_event;
    fpep_pkg::fpep_power_t     power;
    logic                      program_mode;
    logic                      erase_mode;
    logic                      program_verify_mode;
    logic                      erase_verify_mode;
    logic [15:0]               erase_block_enable;
    logic                      read_permit;
    logic                      read_undefined;
    logic                      error_protect;
    logic [7:0]                rd;
    int                        n_fail;
    int                        comparisons;

    fpep_protect #(.BLOCK_BITS(8)) fpep_protect_i (
        .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_event(cpu_event),
        .power(power), .program_mode(program_mode), .erase_mode(erase_mode),
        .program_verify_mode(program_verify_mode), .erase_verify_mode(erase_verify_mode),
        .erase_block_enable(erase_block_enable), .read_permit(read_permit),
        .read_undefined(read_undefined), .error_protect(error_protect));

    fpep_cpu_model fpep_cpu_model_i (
        .sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_event(cpu_event), .power(power));

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic check_reg(input logic [1:0] addr, input logic [7:0] exp);
        fpep_cpu_model_i.read_reg(addr, rd);
        check({8'h00, rd}, {8'h00, exp});
    endtask : check_reg

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : step

    task automatic wr(input logic [1:0] addr, input logic [7:0] data);
        fpep_cpu_model_i.write_reg(addr, data);
    endtask : wr

    task automatic do_reset;
        @(posedge sys_clk);
        reset <= 1'b1;
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
    endtask : do_reset

    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (5000) @(posedge sys_clk);
        n_fail++;
        $display("[ERR] %0t ns: run did not finish in time", $time);
        tally_and_finish();
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        reset = 1'b1;
        n_fail = 0;
        comparisons = 0;
        do_reset();
        step(0);
        check(read_permit, 1'b1);
        for (int a = 0; a < 4; a++) check_reg(2'(a), 8'h00);
        $display("test reset_state done");

        for (int b = 0; b < 2; b++) begin
            wr(fpep_pkg::OFF_CTRL_ONE, 8'h01 << b);
            step(2);
            check({program_mode, erase_mode}, 2'b00);
        end
        wr(fpep_pkg::OFF_CTRL_ONE, 8'h41);
        step(1);
        check({program_mode, read_permit, read_undefined}, 3'b101);
        check_reg(fpep_pkg::OFF_CTRL_ONE, 8'h41);
        for (int v = 0; v < 2; v++) begin
            wr(fpep_pkg::OFF_CTRL_ONE, 8'h40 | (8'h04 << v));
            step(2);
            check({program_verify_mode, erase_verify_mode, read_permit}, 3'b101 ^ {v[0], v[0], 1'b0});
        end
        wr(fpep_pkg::OFF_CTRL_ONE, 8'h40);
        step(2);
        check(read_permit, 1'b0);
        $display("test software_protect done");

        wr(fpep_pkg::OFF_SEL_TWO, 8'h10);
        wr(fpep_pkg::OFF_CTRL_ONE, 8'h42);
        step(1);
        for (int c = 0; c < 20; c++) begin
            check({erase_mode, erase_block_enable}, 17'h11000);
            step(1);
        end
        wr(fpep_pkg::OFF_CTRL_ONE, 8'h40);
        step(1);
        check({erase_mode, erase_block_enable}, 17'h00000);
        do_reset();
        wr(fpep_pkg::OFF_CTRL_ONE, 8'h42);
        step(1);
        check(erase_block_enable, 16'h0000);
        $display("test erase_select done");

        for (int e = 0; e < 3; e++) begin
            do_reset();
            wr(fpep_pkg::OFF_SEL_ONE, 8'h01);
            wr(fpep_pkg::OFF_CTRL_ONE, 8'h41);
            step(1);
            fpep_cpu_model_i.pulse_event(fpep_pkg::fpep_cpu_event_t'(3'b001 << e));
            step(0);
            check({error_protect, program_mode}, 2'b10);
            check_reg(fpep_pkg::OFF_CTRL_ONE, 8'h41);
            check_reg(fpep_pkg::OFF_SEL_ONE, 8'h01);
            wr(fpep_pkg::OFF_CTRL_TWO, 8'h00);
            check_reg(fpep_pkg::OFF_CTRL_TWO, 8'h80);
            wr(fpep_pkg::OFF_CTRL_ONE, 8'h42);
            step(2);
            check({erase_mode, program_mode}, 2'b00);
            wr(fpep_pkg::OFF_CTRL_ONE, 8'h44);
            step(2);
            check(program_verify_mode, 1'b1);
            fpep_cpu_model_i.pulse_power(fpep_pkg::fpep_power_t'(6'h08));
            step(1);
            check_reg(fpep_pkg::OFF_CTRL_ONE, 8'h00);
            check(error_protect, 1'b1);
            fpep_cpu_model_i.pulse_power(fpep_pkg::fpep_power_t'(6'h10));
            step(1);
            check(error_protect, 1'b0);
        end
        $display("test error_protect done");

        for (int p = 0; p < 6; p++) begin
            do_reset();
            wr(fpep_pkg::OFF_SEL_ONE, 8'h02);
            wr(fpep_pkg::OFF_CTRL_ONE, 8'h42);
            step(1);
            check(erase_mode, 1'b1);
            fpep_cpu_model_i.pulse_power(fpep_pkg::fpep_power_t'(6'h01 << p));
            step(1);
            check(erase_mode, 1'b0);
            check_reg(fpep_pkg::OFF_SEL_ONE, 8'h00);
            check_reg(fpep_pkg::OFF_CTRL_ONE, 8'h00);
        end
        wr(fpep_pkg::OFF_CTRL_ONE, 8'h41);
        step(1);
        do_reset();
        step(0);
        check(program_mode, 1'b0);
        $display("test hardware_protect done");
        tally_and_finish();
    end
endmodule : test_flash_program_erase_protection
